// *** sap_pkg.sv ***
// Purpose: constants for the sag and peak detect register bank
// Assumes: 9-bit extended register address, 8-bit data
// Notes:   offsets are byte addresses in the extended register space
package sap_pkg;

   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int SAG_W = 22;
   localparam int LVL_W = 16;
   localparam int PEAK_W = 22;

   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [8:0] OFS_SAG1_L = 9'h107;
   localparam logic [8:0] OFS_SAG1_M = 9'h108;
   localparam logic [8:0] OFS_SAG1_H = 9'h109;
   localparam logic [8:0] OFS_SAG2_L = 9'h10B;
   localparam logic [8:0] OFS_SAG2_M = 9'h10C;
   localparam logic [8:0] OFS_SAG2_H = 9'h10D;
   localparam logic [8:0] OFS_IPK_L = 9'h10E;
   localparam logic [8:0] OFS_IPK_H = 9'h10F;
   localparam logic [8:0] OFS_VPK_L = 9'h110;
   localparam logic [8:0] OFS_VPK_H = 9'h111;
   localparam logic [8:0] OFS_PEAK_L = 9'h112;
   localparam logic [8:0] OFS_PEAK_M = 9'h113;
   localparam logic [8:0] OFS_PEAK_H = 9'h114;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [21:0] RST_SAG = 22'h000000;
   localparam logic [15:0] RST_IPK = 16'hFFFF;
   localparam logic [15:0] RST_VPK = 16'hFFFF;
   localparam logic [21:0] RST_PEAK = 22'h000000;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage : sap_pkg

// *** sap_pk_if.sv ***
// Purpose: carrier between the register bank and the peak capture unit
// Assumes: single clock domain
// Notes:   sample is two's complement
`timescale 1ns/1ps
interface sap_pk_if #(
   parameter int SAMPLE_W = 23
);
   logic signed [SAMPLE_W-1:0] sample;
   logic sample_valid;
   logic [15:0] level;
   logic [21:0] peak;

   modport cap (
      input sample,
      input sample_valid,
      input level,
      output peak
   );

   modport ctl (
      output sample,
      output sample_valid,
      output level,
      input peak
   );
endinterface : sap_pk_if

// *** sap_peak_cap.sv ***
// Purpose: running absolute peak capture for current channel 1
// Assumes: one sample per sample_valid pulse
// Notes:   most negative sample saturates to full scale
`timescale 1ns/1ps
module sap_peak_cap #(
   parameter int SAMPLE_W = 23
) (
   input wire logic clock_i,  // system clock
   input wire logic rst_n_i,  // async reset, active low
   sap_pk_if.cap pk           // sample in, peak out
);
   localparam logic [21:0] FULL = 22'h3FFFFF;

   logic [SAMPLE_W-1:0] neg_w;
   logic [SAMPLE_W-1:0] mag_w;
   logic [21:0] abs_w;
   logic above_lvl_w;
   logic above_peak_w;
   logic [21:0] peak_q;
   logic [21:0] peak_d;

   assign neg_w = SAMPLE_W'(-pk.sample);
   assign mag_w = pk.sample[SAMPLE_W-1] ? neg_w : pk.sample;
   // saturate: -2**(W-1) has no positive twin
   assign abs_w = (pk.sample[SAMPLE_W-1] && mag_w[SAMPLE_W-1]) ? FULL : mag_w[21:0];
   assign above_lvl_w = abs_w > {6'h00, pk.level};
   assign above_peak_w = abs_w > peak_q;
   assign peak_d = (pk.sample_valid && above_lvl_w && above_peak_w) ? abs_w : peak_q;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         peak_q <= sap_pkg::RST_PEAK;
      end else begin
         peak_q <= peak_d;
      end
   end

   assign pk.peak = peak_q;

   AST_PEAK_CAPTURE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (pk.sample_valid && above_lvl_w && above_peak_w) |=> peak_q == $past(abs_w))
      else $error("peak not captured");
   AST_PEAK_MONOTONIC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      1'b1 |=> peak_q >= $past(peak_q))
      else $error("peak value decreased");
   AST_PEAK_NO_LOW: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (!pk.sample_valid || !above_lvl_w) |=> $stable(peak_q))
      else $error("peak changed without qualifying sample");

endmodule : sap_peak_cap

// *** sap_regs.sv ***
// Purpose: sag level, peak level and peak current registers
// Assumes: one-cycle write and read strobes on the extended register port
// Notes:   read data is registered, valid the cycle after the read strobe
`timescale 1ns/1ps

// Functional notes
// - channel mode 0 blocks channel 2 sag writes; reads return reset value
// - writable current peak level, reset to all ones
// - writable 16-bit voltage peak level, any value, reset to all ones
// - sample magnitude above both current level and stored peak is stored as peak value
// - reading the peak value leaves it unchanged
// - peak value is 22 bits over three bytes, top two bits read zero
// - reset clears all three peak value bytes
// - all registers sit in extended register space, reached only there
module sap_regs #(
   parameter int SAMPLE_W = 23
) (
   input wire logic clock_i,                          // system clock
   input wire logic rst_n_i,                          // async reset, active low
   input wire logic [8:0] sfr_addr_i,                 // extended register address
   input wire logic [7:0] sfr_wdata_i,                // write data
   input wire logic sfr_wr_i,                         // write strobe
   input wire logic sfr_rd_i,                         // read strobe
   output logic [7:0] sfr_rdata_o,                    // registered read data
   input wire logic channel_mode_bit_i,               // channel mode, bit 5 of mode reg
   input wire logic signed [SAMPLE_W-1:0] cur_sample_i, // current channel 1 sample
   input wire logic cur_sample_valid_i,               // sample strobe
   output logic [21:0] sag_level_ch1_o,               // sag level, channel 1
   output logic [21:0] sag_level_ch2_o,               // sag level, channel 2
   output logic [15:0] current_peak_level_o,          // current peak level
   output logic [15:0] voltage_peak_level_o,          // voltage peak level
   output logic [21:0] current_peak_value_o           // captured peak magnitude
);

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // extended space decode
   logic hit_s1l, hit_s1m, hit_s1h, hit_s2l, hit_s2m, hit_s2h;
   logic hit_il, hit_ih, hit_vl, hit_vh, hit_pl, hit_pm, hit_ph;
   assign hit_s1l = sfr_addr_i == sap_pkg::OFS_SAG1_L;
   assign hit_s1m = sfr_addr_i == sap_pkg::OFS_SAG1_M;
   assign hit_s1h = sfr_addr_i == sap_pkg::OFS_SAG1_H;
   assign hit_s2l = sfr_addr_i == sap_pkg::OFS_SAG2_L;
   assign hit_s2m = sfr_addr_i == sap_pkg::OFS_SAG2_M;
   assign hit_s2h = sfr_addr_i == sap_pkg::OFS_SAG2_H;
   assign hit_il = sfr_addr_i == sap_pkg::OFS_IPK_L;
   assign hit_ih = sfr_addr_i == sap_pkg::OFS_IPK_H;
   assign hit_vl = sfr_addr_i == sap_pkg::OFS_VPK_L;
   assign hit_vh = sfr_addr_i == sap_pkg::OFS_VPK_H;
   assign hit_pl = sfr_addr_i == sap_pkg::OFS_PEAK_L;
   assign hit_pm = sfr_addr_i == sap_pkg::OFS_PEAK_M;
   assign hit_ph = sfr_addr_i == sap_pkg::OFS_PEAK_H;

   logic ch2_en_w;
   assign ch2_en_w = channel_mode_bit_i;

   // ----------------------------------------------------------------
   // level registers
   // ----------------------------------------------------------------
   logic [21:0] sag1_q, sag1_d, sag2_q, sag2_d;
   logic [15:0] ipk_q, ipk_d, vpk_q, vpk_d;

   assign sag1_d = {hit_s1h ? sfr_wdata_i[5:0] : sag1_q[21:16],
                    hit_s1m ? sfr_wdata_i : sag1_q[15:8],
                    hit_s1l ? sfr_wdata_i : sag1_q[7:0]};
   assign sag2_d = {(hit_s2h && ch2_en_w) ? sfr_wdata_i[5:0] : sag2_q[21:16],
                    (hit_s2m && ch2_en_w) ? sfr_wdata_i : sag2_q[15:8],
                    (hit_s2l && ch2_en_w) ? sfr_wdata_i : sag2_q[7:0]};
   assign ipk_d = {hit_ih ? sfr_wdata_i : ipk_q[15:8], hit_il ? sfr_wdata_i : ipk_q[7:0]};
   assign vpk_d = {hit_vh ? sfr_wdata_i : vpk_q[15:8], hit_vl ? sfr_wdata_i : vpk_q[7:0]};

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sag1_q <= sap_pkg::RST_SAG;
         sag2_q <= sap_pkg::RST_SAG;
         ipk_q <= sap_pkg::RST_IPK;
         vpk_q <= sap_pkg::RST_VPK;
      end else if (sfr_wr_i) begin
         sag1_q <= sag1_d;
         sag2_q <= sag2_d;
         ipk_q <= ipk_d;
         vpk_q <= vpk_d;
      end
   end

   // ----------------------------------------------------------------
   // peak capture
   // ----------------------------------------------------------------
   sap_pk_if #(.SAMPLE_W(SAMPLE_W)) pk_bus ();
   assign pk_bus.sample = cur_sample_i;
   assign pk_bus.sample_valid = cur_sample_valid_i;
   assign pk_bus.level = ipk_q;

   sap_peak_cap #(.SAMPLE_W(SAMPLE_W)) u_peak (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .pk(pk_bus.cap)
   );

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [21:0] sag2_rd_w;
   logic [7:0] rd_mux_w;
   logic [7:0] rdata_q;
   assign sag2_rd_w = ch2_en_w ? sag2_q : sap_pkg::RST_SAG;
   assign rd_mux_w = hit_s1l ? sag1_q[7:0] :
                     hit_s1m ? sag1_q[15:8] :
                     hit_s1h ? {2'h0, sag1_q[21:16]} :
                     hit_s2l ? sag2_rd_w[7:0] :
                     hit_s2m ? sag2_rd_w[15:8] :
                     hit_s2h ? {2'h0, sag2_rd_w[21:16]} :
                     hit_il ? ipk_q[7:0] :
                     hit_ih ? ipk_q[15:8] :
                     hit_vl ? vpk_q[7:0] :
                     hit_vh ? vpk_q[15:8] :
                     hit_pl ? pk_bus.peak[7:0] :
                     hit_pm ? pk_bus.peak[15:8] :
                     hit_ph ? {2'h0, pk_bus.peak[21:16]} :
                     sap_pkg::RD_UNMAPPED;

   // holds last read data between reads
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 8'h00;
      end else if (sfr_rd_i) begin
         rdata_q <= rd_mux_w;
      end
   end

   assign sfr_rdata_o = rdata_q;
   assign sag_level_ch1_o = sag1_q;
   assign sag_level_ch2_o = sag2_q;
   assign current_peak_level_o = ipk_q;
   assign voltage_peak_level_o = vpk_q;
   assign current_peak_value_o = pk_bus.peak;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // any mapped offset; everything else reads back as the unmapped value
   logic hit_any_w;
   assign hit_any_w = hit_s1l || hit_s1m || hit_s1h || hit_s2l || hit_s2m || hit_s2h ||
                      hit_il || hit_ih || hit_vl || hit_vh || hit_pl || hit_pm || hit_ph;

   sequence s_rd_peak;
      sfr_rd_i && (hit_pl || hit_pm || hit_ph) && !cur_sample_valid_i;
   endsequence
   sequence s_wr_vpk_l;
      sfr_wr_i && hit_vl;
   endsequence

   AST_SAG_HIGH_22: assert property (
      (sfr_wr_i && hit_s1h) |=> sag1_q[21:16] == $past(sfr_wdata_i[5:0]))
      else $error("sag high byte not stored");
   AST_CH2_WR_BLOCKED: assert property (
      (sfr_wr_i && !channel_mode_bit_i) |=> $stable(sag2_q))
      else $error("channel 2 written while disabled");
   AST_CH2_RD_RESET: assert property (
      (sfr_rd_i && !channel_mode_bit_i && (hit_s2l || hit_s2m || hit_s2h))
      |=> sfr_rdata_o == 8'h00)
      else $error("channel 2 read not reset value");
   AST_IPK_WRITE: assert property (
      (sfr_wr_i && hit_ih) |=> current_peak_level_o[15:8] == $past(sfr_wdata_i))
      else $error("current level not written");
   AST_VPK_WR_RD: assert property (
      s_wr_vpk_l ##1 (sfr_rd_i && hit_vl && !sfr_wr_i) |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
      else $error("voltage level readback mismatch");
   AST_PEAK_RD_HOLD: assert property (
      s_rd_peak |=> $stable(current_peak_value_o))
      else $error("peak changed by read");
   AST_PEAK_HIGH_ZERO: assert property (
      (sfr_rd_i && hit_ph) |=> sfr_rdata_o[7:6] == 2'h0)
      else $error("peak high byte top bits set");
   AST_PEAK_RESET: assert property (@(posedge clock_i)
      $rose(rst_n_i) |-> current_peak_value_o == sap_pkg::RST_PEAK)
      else $error("peak not cleared by reset");

   // level reset, byte lanes and read path checks
   AST_LEVEL_RESET: assert property (@(posedge clock_i)
      $rose(rst_n_i) |-> (current_peak_level_o == sap_pkg::RST_IPK &&
                          voltage_peak_level_o == sap_pkg::RST_VPK))
      else $error("peak levels not all ones after reset");
   AST_SAG1_LOW_WRITE: assert property (
      (sfr_wr_i && hit_s1l) |=> sag_level_ch1_o[7:0] == $past(sfr_wdata_i))
      else $error("sag low byte not stored");
   AST_VPK_HIGH_WRITE: assert property (
      (sfr_wr_i && hit_vh) |=> voltage_peak_level_o[15:8] == $past(sfr_wdata_i))
      else $error("voltage level high byte not written");
   AST_VPK_LOW_WRITE: assert property (
      (sfr_wr_i && hit_vl) |=> voltage_peak_level_o[7:0] == $past(sfr_wdata_i))
      else $error("voltage level low byte not written");
   AST_IPK_LOW_WRITE: assert property (
      (sfr_wr_i && hit_il) |=> current_peak_level_o[7:0] == $past(sfr_wdata_i))
      else $error("current level low byte not written");
   AST_CH2_RD_STORED: assert property (
      (sfr_rd_i && channel_mode_bit_i && hit_s2h)
      |=> sfr_rdata_o == {2'h0, $past(sag2_q[21:16])})
      else $error("channel 2 read not stored value");
   AST_PEAK_RD_LOW: assert property (
      (sfr_rd_i && hit_pl) |=> sfr_rdata_o == $past(current_peak_value_o[7:0]))
      else $error("peak low byte read mismatch");
   AST_PEAK_WR_IGNORED: assert property (
      (sfr_wr_i && (hit_pl || hit_pm || hit_ph) && !cur_sample_valid_i)
      |=> $stable(current_peak_value_o))
      else $error("peak value changed by write");
   AST_UNMAPPED_RD: assert property (
      (sfr_rd_i && !hit_any_w) |=> sfr_rdata_o == sap_pkg::RD_UNMAPPED)
      else $error("unmapped read not zero");
   AST_RDATA_HOLD: assert property (
      !sfr_rd_i |=> $stable(sfr_rdata_o))
      else $error("read data changed without a read");

endmodule : sap_regs

// *** sag_and_peak_detect_regs_tb.sv ***
// Purpose: self-checking bench for the sag and peak detect register bank
// Assumes: one-cycle strobes, read data valid the cycle after the strobe
// Notes:   all inputs except the clock driven by non-blocking assignment on the rising edge
`timescale 1ns/1ps
module sag_and_peak_detect_regs_tb;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [8:0] sfr_addr_i = 9'h000;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic sfr_wr_i = 1'b0;
   logic sfr_rd_i = 1'b0;
   logic channel_mode_bit_i = 1'b0;
   logic signed [22:0] cur_sample_i = 23'h000000;
   logic cur_sample_valid_i = 1'b0;
   logic [7:0] sfr_rdata_o;
   logic [21:0] sag_level_ch1_o, sag_level_ch2_o, current_peak_value_o;
   logic [15:0] current_peak_level_o, voltage_peak_level_o;
   logic [7:0] rdat;
   int n_fail = 0;
   int tests_run = 0;

   sap_regs #(.SAMPLE_W(23)) u_dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_rdata_o(sfr_rdata_o), .channel_mode_bit_i(channel_mode_bit_i),
      .cur_sample_i(cur_sample_i), .cur_sample_valid_i(cur_sample_valid_i),
      .sag_level_ch1_o(sag_level_ch1_o), .sag_level_ch2_o(sag_level_ch2_o),
      .current_peak_level_o(current_peak_level_o),
      .voltage_peak_level_o(voltage_peak_level_o),
      .current_peak_value_o(current_peak_value_o)
   );

   initial begin
      forever #20 clock_i = ~clock_i;
   end

   // ---------------------------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk8

   task automatic chk22(input logic [21:0] got, input logic [21:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk22

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clock_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge clock_i);
      sfr_wr_i <= 1'b0;
      // let the write edge settle before any compare
      #1;
   endtask : wr

   task automatic wr_rd(input logic [8:0] a, input logic [7:0] d, input logic [7:0] exp);
      @(posedge clock_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge clock_i);
      sfr_wr_i <= 1'b0;
      sfr_rd_i <= 1'b1;
      @(posedge clock_i);
      sfr_rd_i <= 1'b0;
      #1 chk8(sfr_rdata_o, exp, "write then read");
   endtask : wr_rd

   task automatic rd(input logic [8:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'b1;
      @(posedge clock_i);
      sfr_rd_i <= 1'b0;
      #1 chk8(sfr_rdata_o, exp, "read data");
   endtask : rd

   task automatic smp(input logic [22:0] s, input logic [21:0] exp);
      @(posedge clock_i);
      cur_sample_i <= s;
      cur_sample_valid_i <= 1'b1;
      @(posedge clock_i);
      cur_sample_valid_i <= 1'b0;
      #1 chk22(current_peak_value_o, exp, "peak value");
   endtask : smp

   task automatic set_mode(input logic m);
      @(posedge clock_i);
      channel_mode_bit_i <= m;
   endtask : set_mode

   task automatic do_reset;
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (20) @(posedge clock_i);
      rst_n_i <= 1'b1;
   endtask : do_reset

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_reset_values;
      logic [8:0] at [14] = '{9'h107, 9'h108, 9'h109, 9'h10B, 9'h10C, 9'h10D, 9'h10E,
                              9'h10F, 9'h110, 9'h111, 9'h112, 9'h113, 9'h114, 9'h115};
      logic [7:0] et [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
                              8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 14; i++) begin
         rd(at[i], et[i]);
      end
      $display("test reset values done");
   endtask : test_reset_values

   task automatic test_sag_levels;
      set_mode(1'b1);
      wr(9'h107, 8'hA5);
      wr(9'h108, 8'h3C);
      wr(9'h109, 8'h3F);
      rd(9'h109, 8'h3F);
      chk22(sag_level_ch1_o, 22'h3F3CA5, "sag ch1");
      set_mode(1'b0);
      wr(9'h10B, 8'h11);
      wr(9'h10D, 8'h2A);
      chk22(sag_level_ch2_o, 22'h000000, "sag ch2 masked");
      set_mode(1'b1);
      wr(9'h10B, 8'h5A);
      wr(9'h10C, 8'hC3);
      wr(9'h10D, 8'h15);
      rd(9'h10D, 8'h15);
      chk22(sag_level_ch2_o, 22'h15C35A, "sag ch2");
      set_mode(1'b0);
      rd(9'h10C, 8'h00);
      wr(9'h10C, 8'h00);
      chk22(sag_level_ch2_o, 22'h15C35A, "sag ch2 held");
      $display("test sag levels done");
   endtask : test_sag_levels

   task automatic test_peak_levels;
      wr(9'h110, 8'h00);
      wr(9'h111, 8'h00);
      chk22({6'h00, voltage_peak_level_o}, 22'h000000, "vlevel min");
      wr(9'h111, 8'hFF);
      wr(9'h110, 8'hFE);
      rd(9'h111, 8'hFF);
      chk22({6'h00, voltage_peak_level_o}, 22'h00FFFE, "vlevel");
      wr(9'h10E, 8'h10);
      wr(9'h10F, 8'h00);
      rd(9'h10E, 8'h10);
      chk22({6'h00, current_peak_level_o}, 22'h000010, "ilevel");
      wr_rd(9'h110, 8'h5A, 8'h5A);
      $display("test peak levels done");
   endtask : test_peak_levels

   task automatic test_peak_capture;
      smp(23'h000010, 22'h000000);
      smp(23'h7FFFE0, 22'h000020);
      smp(23'h000018, 22'h000020);
      smp(23'h400000, 22'h3FFFFF);
      wr(9'h112, 8'h00);
      rd(9'h112, 8'hFF);
      rd(9'h113, 8'hFF);
      rd(9'h114, 8'h3F);
      rd(9'h114, 8'h3F);
      chk22(current_peak_value_o, 22'h3FFFFF, "peak after reads");
      $display("test peak capture done");
   endtask : test_peak_capture

   task automatic test_reset_clears;
      do_reset();
      #1 chk22(current_peak_value_o, 22'h000000, "peak after reset");
      rd(9'h112, 8'h00);
      rd(9'h113, 8'h00);
      rd(9'h114, 8'h00);
      $display("test reset clears done");
   endtask : test_reset_clears

   initial begin
      do_reset();
      test_reset_values();
      test_sag_levels();
      test_peak_levels();
      test_peak_capture();
      test_reset_clears();
      tally_and_finish();
   end

   // hang guard, well beyond the roughly 150 cycles the tests need
   initial begin
      repeat (5000) @(posedge clock_i);
      n_fail++;
      tally_and_finish();
   end
endmodule : sag_and_peak_detect_regs_tb
